// ==== hw/pport_uart_cfg_defines.svh ====
// register indices, byte addresses, field positions, reset values, timing
// assumes: included by bare name; byte address is four times the index
`ifndef PPORT_UART_CFG_DEFINES_SVH
`define PPORT_UART_CFG_DEFINES_SVH

// ----------------------------------------------------------------
// register indices and logical device numbers
// ----------------------------------------------------------------
`define IDX_LD_SELECT 8'h07
`define IDX_STATUS 8'h08
`define IDX_PP_CTRL 8'hf0
`define IDX_PP_ROUTE 8'hf1
`define IDX_SP1_OPT 8'hf0
`define LD_PPORT 8'h03
`define LD_SERIAL1 8'h04
`define BYTE_ADDR(idx) (12'(idx) << 2)

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PP_CTRL 8'h3c
`define RST_PP_ROUTE 8'h00
`define RST_SP1_OPT 8'h00
`define RST_LD_SELECT 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PP_MODE_LSB 0
`define PP_THR_LSB 3
`define PP_STYLE_BIT 7
`define ROUTE_DMA_LSB 0
`define ROUTE_IRQ_LSB 3
`define ROUTE_USED_MASK 8'h3f
`define SP1_MIDI_BIT 0
`define SP1_HS_BIT 1
`define SP1_SHARE_BIT 7

// ----------------------------------------------------------------
// protocol codes and timing
// ----------------------------------------------------------------
`define PP_MODE_PRINTER 3'h4
`define PP_MODE_SPP 3'h0
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`define MCLK_MHZ 40
`define PP_PULSE_NS 100
`define PP_PULSE_CYC ((`PP_PULSE_NS * `MCLK_MHZ + 999) / 1000)

`endif

// ==== hw/pport_uart_cfg_pkg.sv ====
// types shared by the configuration block and its bench
// assumes: constants live in pport_uart_cfg_defines.svh
package pport_uart_cfg_pkg;
   typedef logic [2:0] pp_mode_t;
   typedef logic [3:0] irq_line_t;
   typedef enum logic [2:0] {sel_none, sel_ld, sel_stat, sel_pp, sel_route,
      sel_sp1} reg_sel_t;
   typedef enum logic [1:0] {irq_idle, irq_pulse, irq_hold} pulse_state_t;
endpackage

// ==== hw/pport_uart_cfg.sv ====
// parallel port and serial port 1 logical device configuration bank
// assumes: AXI4-Lite master, one clock mclk, synchronous reset rst,
// pin inputs synchronous to mclk, pin enables resolved outside
//
// Functional notes
// RULE1 - three-bit field picks parallel port mode; printer mode 100 at reset
// RULE2 - four-bit FIFO threshold field, reset value 0111
// RULE3 - style one: interrupt pin pulses low then floats
// RULE4 - style zero: interrupt pin follows acknowledge level in advanced modes
// RULE5 - style bit ignored in printer and standard bidirectional modes
// RULE6 - DMA field: 000 jumpered channel, 001-011 channels 1-3
// RULE7 - IRQ field: 000 jumpered, then lines 7,9,10,11,14,15,5
// RULE8 - routing bits 7:6 drop writes and read zero
// RULE9 - DMA and IRQ routing mirrored to port's read-only config B
// RULE10 - serial option bit 0 enables instrument interface, reset zero
// RULE11 - serial option bit 1 enables high speed, reset zero
// RULE12 - software writes zero to serial option bits 6:2
// RULE13 - serial option bit 7 makes both UARTs share one line
// RULE14 - separate lines: pin floats when gate 0, else drives request
// RULE15 - shared: pins float if no gate set, else OR gated requests
// RULE16 - reset values load on reset; access needs own device selected
// RULE17 - read-write fields read back last write; reserved bits read zero; serial option bits 6:2 store and read back what was written
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "pport_uart_cfg_defines.svh"

module pport_uart_cfg #(
   parameter int ADDR_W = 12
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic ack_n,
   input wire logic pp_irq_req,
   input wire logic uart1_req,
   input wire logic uart2_req,
   input wire logic uart1_gate,
   input wire logic uart2_gate,
   output pport_uart_cfg_pkg::pp_mode_t pp_mode,
   output logic [3:0] fifo_threshold,
   output logic interrupt_output_style,
   output logic [2:0] cfgb_dma_sel,
   output logic [2:0] cfgb_irq_sel,
   output pport_uart_cfg_pkg::irq_line_t irq_line_num,
   output logic midi_en,
   output logic high_speed_en,
   output logic share_irq,
   output logic port_interrupt_output_o,
   output logic port_interrupt_output_oe,
   output logic uart1_irq_o,
   output logic uart1_irq_oe,
   output logic uart2_irq_o,
   output logic uart2_irq_oe
);
   import pport_uart_cfg_pkg::*;

   localparam int PULSE_CYC = `PP_PULSE_CYC < 1 ? 1 : `PP_PULSE_CYC;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic [7:0] ld_q, ld_d;

   // the shared index only maps to the device that is selected
   function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a,
                                       input logic [7:0] ld);
      reg_sel_t s;
      s = sel_none;
      if (a == ADDR_W'(`BYTE_ADDR(`IDX_LD_SELECT))) begin
         s = sel_ld;
      end else if (a == ADDR_W'(`BYTE_ADDR(`IDX_STATUS))) begin
         s = sel_stat;
      end else if (ld == `LD_PPORT) begin // [RULE16]
         if (a == ADDR_W'(`BYTE_ADDR(`IDX_PP_CTRL))) begin
            s = sel_pp;
         end else if (a == ADDR_W'(`BYTE_ADDR(`IDX_PP_ROUTE))) begin
            s = sel_route;
         end
      end else if (ld == `LD_SERIAL1 &&
                   a == ADDR_W'(`BYTE_ADDR(`IDX_SP1_OPT))) begin
         s = sel_sp1; // [RULE16]
      end
      return s;
   endfunction

   // ----------------------------------------------------------------
   // write channel and configuration registers
   // ----------------------------------------------------------------
   logic aw_got_q, aw_got_d, w_got_q, w_got_d;
   logic [ADDR_W-1:0] waddr_q, waddr_d;
   logic [7:0] wbyte_q, wbyte_d;
   logic wlane_q, wlane_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic [7:0] pp_ctrl_q, pp_ctrl_d, route_q, route_d, sp1_q, sp1_d;
   logic wr_fire;
   reg_sel_t wsel;

   assign awready = !aw_got_q && !bvalid_q;
   assign wready = !w_got_q && !bvalid_q;
   assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
   assign wsel = decode(waddr_q, ld_q);

   // address and data are latched apart so either may come first
   always_comb begin
      aw_got_d = aw_got_q;
      w_got_d = w_got_q;
      waddr_d = waddr_q;
      wbyte_d = wbyte_q;
      wlane_d = wlane_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      ld_d = ld_q;
      pp_ctrl_d = pp_ctrl_q;
      route_d = route_q;
      sp1_d = sp1_q;
      if (awvalid && awready) begin
         aw_got_d = 1'b1;
         waddr_d = awaddr;
      end
      if (wvalid && wready) begin
         w_got_d = 1'b1;
         wbyte_d = wdata[7:0];
         wlane_d = wstrb[0];
      end
      if (bvalid_q && bready) begin
         bvalid_d = 1'b0;
      end
      if (wr_fire) begin
         aw_got_d = 1'b0;
         w_got_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = (wsel == sel_none || wsel == sel_stat) ?
                   `AXI_SLVERR : `AXI_OKAY;
         // only the low lane carries these 8-bit registers
         if (wlane_q) begin
            case (wsel)
               sel_ld: ld_d = wbyte_q;
               sel_pp: pp_ctrl_d = wbyte_q; // [RULE1] [RULE2] [RULE17]
               sel_route: route_d = wbyte_q & `ROUTE_USED_MASK; // [RULE8]
               sel_sp1: sp1_d = wbyte_q; // [RULE10] [RULE11] [RULE13]
               default: ;
            endcase
         end
      end
   end

   // register stage; reset loads every documented default
   always_ff @(posedge mclk) begin
      if (rst) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         waddr_q <= '0;
         wbyte_q <= 8'h00;
         wlane_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `AXI_OKAY;
         ld_q <= `RST_LD_SELECT;
         pp_ctrl_q <= `RST_PP_CTRL; // [RULE16]
         route_q <= `RST_PP_ROUTE;
         sp1_q <= `RST_SP1_OPT;
      end else begin
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         waddr_q <= waddr_d;
         wbyte_q <= wbyte_d;
         wlane_q <= wlane_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         ld_q <= ld_d;
         pp_ctrl_q <= pp_ctrl_d;
         route_q <= route_d;
         sp1_q <= sp1_d;
      end
   end

   assign bvalid = bvalid_q;
   assign bresp = bresp_q;

   // ----------------------------------------------------------------
   // configuration outputs
   // ----------------------------------------------------------------
   assign pp_mode = pp_ctrl_q[`PP_MODE_LSB +: 3]; // [RULE1]
   assign fifo_threshold = pp_ctrl_q[`PP_THR_LSB +: 4]; // [RULE2]
   assign interrupt_output_style = pp_ctrl_q[`PP_STYLE_BIT];
   assign cfgb_dma_sel = route_q[`ROUTE_DMA_LSB +: 3]; // [RULE6] [RULE9]
   assign cfgb_irq_sel = route_q[`ROUTE_IRQ_LSB +: 3]; // [RULE9]
   assign midi_en = sp1_q[`SP1_MIDI_BIT]; // [RULE10]
   assign high_speed_en = sp1_q[`SP1_HS_BIT]; // [RULE11]
   assign share_irq = sp1_q[`SP1_SHARE_BIT]; // [RULE13]

   // irq line number; zero means the jumpered line
   always_comb begin
      case (cfgb_irq_sel) // [RULE7]
         3'h1: irq_line_num = 4'h7;
         3'h2: irq_line_num = 4'h9;
         3'h3: irq_line_num = 4'ha;
         3'h4: irq_line_num = 4'hb;
         3'h5: irq_line_num = 4'he;
         3'h6: irq_line_num = 4'hf;
         3'h7: irq_line_num = 4'h5;
         default: irq_line_num = 4'h0;
      endcase
   end

   // ----------------------------------------------------------------
   // parallel port interrupt pin
   // ----------------------------------------------------------------
   pulse_state_t pst_q, pst_d;
   logic [7:0] pcnt_q, pcnt_d;
   logic req_q, pio_q, pio_d, poe_q, poe_d;
   logic legacy, pulse_mode;

   assign legacy = pp_mode == `PP_MODE_PRINTER || pp_mode == `PP_MODE_SPP;
   assign pulse_mode = !legacy && interrupt_output_style;

   // pulse low for a fixed time on each new request, then float
   always_comb begin
      pst_d = pst_q;
      pcnt_d = pcnt_q;
      case (pst_q)
         irq_idle: if (pulse_mode && pp_irq_req && !req_q) begin
            pst_d = irq_pulse;
            pcnt_d = 8'(PULSE_CYC - 1);
         end
         irq_pulse: if (pcnt_q == 8'h00) begin
            pst_d = irq_hold;
         end else begin
            pcnt_d = pcnt_q - 8'h01;
         end
         irq_hold: if (!pp_irq_req) begin
            pst_d = irq_idle;
         end
         default: pst_d = irq_idle;
      endcase
      if (!pulse_mode) begin
         pst_d = irq_idle;
      end
      if (legacy) begin
         pio_d = pp_irq_req; // style ignored here [RULE5]
         poe_d = 1'b1;
      end else if (interrupt_output_style) begin
         pio_d = 1'b0; // [RULE3]
         poe_d = pst_d == irq_pulse;
      end else begin
         pio_d = ack_n; // [RULE4]
         poe_d = 1'b1;
      end
   end

   // pin is registered so its level never glitches on a decode change
   always_ff @(posedge mclk) begin
      if (rst) begin
         pst_q <= irq_idle;
         pcnt_q <= 8'h00;
         req_q <= 1'b0;
         pio_q <= 1'b0;
         poe_q <= 1'b0;
      end else begin
         pst_q <= pst_d;
         pcnt_q <= pcnt_d;
         req_q <= pp_irq_req;
         pio_q <= pio_d;
         poe_q <= poe_d;
      end
   end

   assign port_interrupt_output_o = pio_q;
   assign port_interrupt_output_oe = poe_q;

   // ----------------------------------------------------------------
   // uart interrupt pins
   // ----------------------------------------------------------------
   logic u1o_q, u1o_d, u1e_q, u1e_d, u2o_q, u2o_d, u2e_q, u2e_d;
   logic any_gate, any_req;

   assign any_gate = uart1_gate || uart2_gate;
   assign any_req = (uart1_req && uart1_gate) || (uart2_req && uart2_gate);

   // separate lines follow each gate; shared lines merge both
   always_comb begin
      if (share_irq) begin
         u1e_d = any_gate; // [RULE15]
         u2e_d = any_gate;
         u1o_d = any_req;
         u2o_d = any_req;
      end else begin
         u1e_d = uart1_gate; // [RULE14]
         u2e_d = uart2_gate;
         u1o_d = uart1_req && uart1_gate;
         u2o_d = uart2_req && uart2_gate;
      end
   end

   // registered pin levels
   always_ff @(posedge mclk) begin
      if (rst) begin
         u1o_q <= 1'b0;
         u1e_q <= 1'b0;
         u2o_q <= 1'b0;
         u2e_q <= 1'b0;
      end else begin
         u1o_q <= u1o_d;
         u1e_q <= u1e_d;
         u2o_q <= u2o_d;
         u2e_q <= u2e_d;
      end
   end

   assign uart1_irq_o = u1o_q;
   assign uart1_irq_oe = u1e_q;
   assign uart2_irq_o = u2o_q;
   assign uart2_irq_oe = u2e_q;

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   reg_sel_t rsel;

   assign arready = !rvalid_q;
   assign rsel = decode(araddr, ld_q);

   // one read in flight; data is captured at the address handshake
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
      end
      if (arvalid && arready) begin
         rvalid_d = 1'b1;
         rresp_d = `AXI_OKAY;
         case (rsel)
            sel_ld: rdata_d = {24'h0, ld_q};
            sel_stat: rdata_d = {26'h0, u2o_q, u2e_q, u1o_q, u1e_q,
                                 pio_q, poe_q};
            sel_pp: rdata_d = {24'h0, pp_ctrl_q}; // [RULE17]
            sel_route: rdata_d = {24'h0, route_q}; // [RULE8]
            sel_sp1: rdata_d = {24'h0, sp1_q}; // [RULE12]
            default: begin
               rdata_d = 32'h0;
               rresp_d = `AXI_SLVERR;
            end
         endcase
      end
   end

   // read response registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= `AXI_OKAY;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   chk_reset_defaults: // [RULE2] [RULE16]
   assert property ($fell(rst) |-> pp_ctrl_q == `RST_PP_CTRL &&
      route_q == `RST_PP_ROUTE && sp1_q == `RST_SP1_OPT && !midi_en)
      else $error("config registers missed reset values");
   chk_route_reserved: // [RULE8]
   assert property ((wr_fire && wsel == sel_route && wlane_q) |=>
      route_q[7:6] == 2'h0 && route_q[5:0] == $past(wbyte_q[5:0]))
      else $error("routing write stored wrong bits");
   chk_cfgb_mirror: // [RULE9]
   assert property ((wr_fire && wsel == sel_route && wlane_q) |=>
      cfgb_dma_sel == $past(wbyte_q[2:0]) &&
      cfgb_irq_sel == $past(wbyte_q[5:3]))
      else $error("config B mirror not updated");
   chk_ld_gating: // [RULE16]
   assert property ((wr_fire && ld_q != `LD_PPORT) |=> $stable(pp_ctrl_q))
      else $error("port register written while deselected");
   chk_style_pulse: // [RULE3]
   assert property ((pulse_mode && pp_irq_req && !req_q && pst_q == irq_idle)
      |=> port_interrupt_output_oe && !port_interrupt_output_o)
      else $error("pulse style did not drive low");
   chk_ack_tracking: // [RULE4]
   assert property ((!legacy && !interrupt_output_style) |=>
      port_interrupt_output_oe && port_interrupt_output_o == $past(ack_n))
      else $error("interrupt pin not following acknowledge");
   chk_legacy_style: // [RULE5]
   assert property (legacy |=> port_interrupt_output_oe &&
      port_interrupt_output_o == $past(pp_irq_req))
      else $error("style bit acted in legacy mode");
   chk_separate_pins: // [RULE14]
   assert property (!share_irq |=> uart1_irq_oe == $past(uart1_gate) &&
      uart2_irq_oe == $past(uart2_gate) &&
      uart1_irq_o == $past(uart1_req && uart1_gate))
      else $error("separate uart pin wrong");
   chk_shared_pins: // [RULE15]
   assert property (share_irq |=> uart1_irq_oe == $past(any_gate) &&
      uart2_irq_o == $past(any_req) && uart1_irq_o == uart2_irq_o)
      else $error("shared uart pins wrong");
   chk_read_back: // [RULE17]
   assert property ((arvalid && arready && rsel == sel_pp) |=>
      rvalid && rdata == {24'h0, $past(pp_ctrl_q)})
      else $error("read back mismatch");

endmodule

// ==== verif/pport_uart_cfg_test.sv ====
// self-checking bench for the parallel and serial port config bank
// assumes: design and defines header compiled first; bench drives all
// pins itself with one 40 MHz clock and a synchronous reset
`timescale 1ns/1ps
`include "pport_uart_cfg_defines.svh"

module pport_uart_cfg_test;
   import pport_uart_cfg_pkg::*;
   localparam logic [11:0] a_ld = `BYTE_ADDR(`IDX_LD_SELECT);
   localparam logic [11:0] a_stat = `BYTE_ADDR(`IDX_STATUS);
   localparam logic [11:0] a_ctrl = `BYTE_ADDR(`IDX_PP_CTRL);
   localparam logic [11:0] a_route = `BYTE_ADDR(`IDX_PP_ROUTE);
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic bready = 1'b1, rready = 1'b1;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic ack_n = 1'b1, pp_irq_req = 1'b0;
   logic uart1_req = 1'b0, uart2_req = 1'b0;
   logic uart1_gate = 1'b0, uart2_gate = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   pp_mode_t pp_mode;
   irq_line_t irq_line_num;
   logic [3:0] fifo_threshold;
   logic [2:0] cfgb_dma_sel, cfgb_irq_sel;
   logic interrupt_output_style, midi_en, high_speed_en, share_irq;
   logic port_interrupt_output_o, port_interrupt_output_oe;
   logic uart1_irq_o, uart1_irq_oe, uart2_irq_o, uart2_irq_oe;
   // bench model of the register state
   logic [7:0] m_ctrl, m_route, m_sp1, m_ld, rnd;
   int irq_tab[8] = '{0, 7, 9, 10, 11, 14, 15, 5};
   int n_errors = 0;
   int tests_run = 0;

   always #12.5 mclk = ~mclk;

   pport_uart_cfg #(.ADDR_W(12)) u_pport_uart_cfg (
      .mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .ack_n(ack_n), .pp_irq_req(pp_irq_req), .uart1_req(uart1_req),
      .uart2_req(uart2_req), .uart1_gate(uart1_gate),
      .uart2_gate(uart2_gate), .pp_mode(pp_mode),
      .fifo_threshold(fifo_threshold),
      .interrupt_output_style(interrupt_output_style),
      .cfgb_dma_sel(cfgb_dma_sel), .cfgb_irq_sel(cfgb_irq_sel),
      .irq_line_num(irq_line_num), .midi_en(midi_en),
      .high_speed_en(high_speed_en), .share_irq(share_irq),
      .port_interrupt_output_o(port_interrupt_output_o),
      .port_interrupt_output_oe(port_interrupt_output_oe),
      .uart1_irq_o(uart1_irq_o), .uart1_irq_oe(uart1_irq_oe),
      .uart2_irq_o(uart2_irq_o), .uart2_irq_oe(uart2_irq_oe));

   // ----------------------------------------------------------------
   // comparison, random source and verdict
   // ----------------------------------------------------------------
   task automatic cmp_val(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_resp(input string nm, input logic [1:0] e,
         input logic [1:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // eight-bit shift register, fixed start so runs repeat
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // bus master; entered right after a rising edge
   // ----------------------------------------------------------------
   // readies are sampled 1 ns after the edge, stable until the next one
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [1:0] r);
      logic pa, pw, ra, rw, b;
      int n;
      pa = 1'b1;
      pw = 1'b1;
      b = 1'b0;
      n = 0;
      r = 2'h3;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while ((pa || pw) && n < 100) begin
         #1;
         ra = (awready === 1'b1);
         rw = (wready === 1'b1);
         @(posedge mclk);
         if (pa && ra) begin
            awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (pw && rw) begin
            wvalid <= 1'b0;
            pw = 1'b0;
         end
         n++;
      end
      while (!b && n < 100) begin
         #1;
         b = (bvalid === 1'b1);
         r = bresp;
         @(posedge mclk);
         n++;
      end
      if (!b) begin
         n_errors++;
         $display("mismatch bvalid expected 1 seen 0");
      end
   endtask

   task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
         output logic [1:0] r);
      logic pa, ra, v;
      int n;
      pa = 1'b1;
      v = 1'b0;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      while (pa && n < 100) begin
         #1;
         ra = (arready === 1'b1);
         @(posedge mclk);
         if (ra) begin
            arvalid <= 1'b0;
            pa = 1'b0;
         end
         n++;
      end
      while (!v && n < 100) begin
         #1;
         v = (rvalid === 1'b1);
         d = rdata;
         r = rresp;
         @(posedge mclk);
         n++;
      end
      if (!v) begin
         n_errors++;
         $display("mismatch rvalid expected 1 seen 0");
      end
   endtask

   // ----------------------------------------------------------------
   // model decode; registers only answer under their own device
   // ----------------------------------------------------------------
   function automatic logic [33:0] model_rd(input logic [11:0] a);
      if (a == a_ld) return {`AXI_OKAY, 24'h0, m_ld};
      if (a == a_ctrl && m_ld == `LD_PPORT) return {`AXI_OKAY, 24'h0, m_ctrl};
      if (a == a_ctrl && m_ld == `LD_SERIAL1)
         return {`AXI_OKAY, 24'h0, m_sp1};
      if (a == a_route && m_ld == `LD_PPORT)
         return {`AXI_OKAY, 24'h0, m_route};
      return {`AXI_SLVERR, 32'h0};
   endfunction

   task automatic wr(input logic [11:0] a, input logic [7:0] d,
         input logic [3:0] s = 4'hf);
      logic [1:0] r, e;
      axi_write(a, {24'h0, d}, s, r);
      e = 2'(model_rd(a) >> 32);
      if (e == `AXI_OKAY && s[0]) begin
         if (a == a_ld) m_ld = d;
         else if (a == a_route) m_route = d & `ROUTE_USED_MASK;
         else if (m_ld == `LD_PPORT) m_ctrl = d;
         else m_sp1 = d;
      end
      cmp_resp("bresp", e, r);
   endtask

   task automatic rd(input logic [11:0] a);
      logic [31:0] d;
      logic [1:0] r;
      logic [33:0] e;
      axi_read(a, d, r);
      e = model_rd(a);
      cmp_val("rdata", e[31:0], d);
      cmp_resp("rresp", e[33:32], r);
   endtask

   // configuration outputs against the model
   task automatic check_cfg();
      #1;
      cmp_val("pp_mode", 32'(m_ctrl[2:0]), 32'(pp_mode));
      cmp_val("fifo_thr", 32'(m_ctrl[6:3]), 32'(fifo_threshold));
      cmp_val("style", 32'(m_ctrl[7]),
         32'(interrupt_output_style));
      cmp_val("dma", 32'(m_route[2:0]), 32'(cfgb_dma_sel));
      cmp_val("irq", 32'(m_route[5:3]), 32'(cfgb_irq_sel));
      cmp_val("line", 32'(irq_tab[m_route[5:3]]),
         32'(irq_line_num));
      cmp_val("midi", 32'(m_sp1[0]), 32'(midi_en));
      cmp_val("hs", 32'(m_sp1[1]), 32'(high_speed_en));
      cmp_val("share", 32'(m_sp1[7]), 32'(share_irq));
      @(posedge mclk);
   endtask

   // pins are registered, so settle two edges before looking
   task automatic pin_step(input logic [5:0] v);
      logic g1, g2, q;
      {ack_n, pp_irq_req, uart1_req, uart2_req, uart1_gate, uart2_gate} <= v;
      repeat (2) @(posedge mclk);
      #1;
      g1 = uart1_gate;
      g2 = uart2_gate;
      q = (uart1_req & g1) | (uart2_req & g2);
      if (m_ctrl[2:0] == `PP_MODE_PRINTER || m_ctrl[2:0] == `PP_MODE_SPP) begin
         cmp_val("port_o", pp_irq_req, port_interrupt_output_o);
         cmp_val("port_oe", 1'b1, port_interrupt_output_oe);
      end else if (!m_ctrl[7]) begin
         cmp_val("port_o", ack_n, port_interrupt_output_o);
         cmp_val("port_oe", 1'b1, port_interrupt_output_oe);
      end
      if (!m_sp1[7]) begin
         cmp_val("u1_oe", g1, uart1_irq_oe);
         cmp_val("u1_o", uart1_req & g1, uart1_irq_o);
         cmp_val("u2_oe", g2, uart2_irq_oe);
         cmp_val("u2_o", uart2_req & g2, uart2_irq_o);
      end else begin
         cmp_val("u1_oe", g1 | g2, uart1_irq_oe);
         cmp_val("u1_o", q, uart1_irq_o);
         cmp_val("u2_oe", g1 | g2, uart2_irq_oe);
         cmp_val("u2_o", q, uart2_irq_o);
      end
      @(posedge mclk);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      int cnt;
      logic [7:0] cfg [3][2];
      cfg = '{'{8'hbc, 8'h00}, '{8'h39, 8'h83}, '{8'hb8, 8'h80}};
      m_ctrl = `RST_PP_CTRL;
      m_route = `RST_PP_ROUTE;
      m_sp1 = `RST_SP1_OPT;
      m_ld = `RST_LD_SELECT;
      rnd = 8'h12;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(a_ctrl);
      wr(a_ld, `LD_PPORT);
      rd(a_ctrl);
      rd(a_route);
      check_cfg();
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         wr(a_ctrl, {rnd[7:3], 3'(i)});
         rd(a_ctrl);
         check_cfg();
         rnd = lfsr(rnd);
         wr(a_route, {rnd[7:6], 3'(i), rnd[0], 2'(i)});
         rd(a_route);
         check_cfg();
      end
      $display("test fields done");
      wr(a_stat, 8'hff);
      wr(12'h100, 8'h12);
      rd(12'h100);
      wr(a_ctrl, 8'h55, 4'he);
      rd(a_ctrl);
      wr(a_ld, `LD_SERIAL1);
      wr(a_route, 8'h3f);
      wr(a_ctrl, 8'h83);
      rd(a_ctrl);
      wr(a_ld, `LD_PPORT);
      rd(a_ctrl);
      check_cfg();
      $display("test decode done");
      for (int k = 0; k < 3; k++) begin
         wr(a_ld, `LD_PPORT);
         wr(a_ctrl, cfg[k][0]);
         wr(a_ld, `LD_SERIAL1);
         wr(a_ctrl, cfg[k][1]);
         check_cfg();
         for (int v = 0; v < 64; v++) pin_step(6'(v));
      end
      $display("test pins done");
      wr(a_ld, `LD_PPORT);
      wr(a_ctrl, 8'hba);
      pp_irq_req <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      cmp_val("idle_oe", 1'b0, port_interrupt_output_oe);
      @(posedge mclk);
      pp_irq_req <= 1'b1;
      cnt = 0;
      repeat (10) begin
         @(posedge mclk);
         #1;
         if (port_interrupt_output_oe === 1'b1 &&
               port_interrupt_output_o === 1'b0) cnt++;
      end
      cmp_val("pulse_len", `PP_PULSE_CYC, 32'(cnt));
      cmp_val("after_oe", 1'b0, port_interrupt_output_oe);
      $display("test pulse done");
      results();
   end

   // watchdog; the whole run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      $display("mismatch watchdog expected done seen hang");
      results();
   end
endmodule
